// File: hw/mad_pkg.sv
// Shared constants for the sector-0 instruction datapath and its register map.
package mad_pkg;
	// System clocks in one instruction cycle.
	localparam int unsigned ICYC_CLKS = 4;
	// Direct addressing reaches sector 0 only, 128 bytes.
	localparam int unsigned MEM_AW = 7;
	localparam int unsigned PC_W = 12;
	localparam int unsigned STACK_D = 4;
	localparam int unsigned FLAG_W = 6;
	// Data memory location that aliases the program counter low byte.
	localparam logic [6:0] PCLOW_ADDR = 7'h06;
	// Register byte offsets.
	localparam logic [7:0] R_OPCODE = 8'h00;
	localparam logic [7:0] R_ACC = 8'h04;
	localparam logic [7:0] R_FLAGS = 8'h08;
	localparam logic [7:0] R_PC = 8'h0c;
	localparam logic [7:0] R_MADDR = 8'h10;
	localparam logic [7:0] R_MDATA = 8'h14;
	localparam logic [7:0] R_STATE = 8'h18;
	// Opcode word fields.
	localparam int unsigned OP_TOMEM = 5;
	localparam int unsigned OP_IMM = 6;
	localparam int unsigned OP_BIT_LSB = 8;
	localparam int unsigned OP_ARG_LSB = 16;
	// Flag register bit positions.
	localparam int unsigned F_ZERO = 0;
	localparam int unsigned F_CARRY = 1;
	localparam int unsigned F_NIB = 2;
	localparam int unsigned F_SRANGE = 3;
	localparam int unsigned F_SCMP = 4;
	localparam int unsigned F_CHZ = 5;
	// Function codes in opcode bits 4..0; unknown codes act as no operation.
	localparam logic [4:0] FN_ADD = 5'h00;
	localparam logic [4:0] FN_ADD_C = 5'h01;
	localparam logic [4:0] FN_SUB = 5'h02;
	localparam logic [4:0] FN_SUB_B = 5'h03;
	localparam logic [4:0] FN_AND = 5'h04;
	localparam logic [4:0] FN_OR = 5'h05;
	localparam logic [4:0] FN_XOR = 5'h06;
	localparam logic [4:0] FN_INVERT = 5'h07;
	localparam logic [4:0] FN_PLUS1 = 5'h08;
	localparam logic [4:0] FN_MINUS1 = 5'h09;
	localparam logic [4:0] FN_ROT_R = 5'h0a;
	localparam logic [4:0] FN_ROT_L = 5'h0b;
	localparam logic [4:0] FN_ROT_RC = 5'h0c;
	localparam logic [4:0] FN_ROT_LC = 5'h0d;
	localparam logic [4:0] FN_BCD_ADJ = 5'h0e;
	localparam logic [4:0] FN_BIT_SET = 5'h0f;
	localparam logic [4:0] FN_BIT_CLR = 5'h10;
	localparam logic [4:0] FN_JUMP = 5'h11;
	localparam logic [4:0] FN_CALL = 5'h12;
	localparam logic [4:0] FN_EXIT = 5'h13;
	localparam logic [4:0] FN_SKIP_Z = 5'h14;
	localparam logic [4:0] FN_SKIP_NZ = 5'h15;
	localparam logic [4:0] FN_SKIP_BZ = 5'h16;
	localparam logic [4:0] FN_SKIP_BNZ = 5'h17;
	// Decimal adjust constants.
	localparam logic [3:0] BCD_DIGIT_MAX = 4'h9;
	localparam logic [8:0] BCD_LO_FIX = 9'h006;
	localparam logic [8:0] BCD_HI_FIX = 9'h060;
	// AXI responses.
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// File: hw/mad_ram.sv
// Sector-0 data memory with a registered read port.
`timescale 1ns/1ps
module mad_ram #(
	parameter int unsigned AW = 7,
	parameter int unsigned DW = 8
) (
	input  wire logic          aclk,
	input  wire logic          we,
	input  wire logic          re,
	input  wire logic [AW-1:0] addr,
	input  wire logic [DW-1:0] wdata,
	output logic      [DW-1:0] rdata_q
);
	logic [DW-1:0] mem [2**AW];

	// A read in the cycle of a write to the same byte returns the old value.
	always_ff @(posedge aclk) begin
		if (we) begin
			mem[addr] <= wdata;
		end
		if (re) begin
			rdata_q <= mem[addr];
		end
	end
endmodule // mad_ram

// File: hw/mad_core.sv
// Sector-0 instruction datapath of the 8-bit core with its AXI4-Lite register slave.
//
// The AXI4-Lite interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps
// Summary of operation
// - Additions from memory or immediate finish in one cycle, updating five flags.
// - Subtractions update the same five flags plus the chained zero flag.
// - Memory-destination subtraction writes accumulator minus byte back to memory.
// - Memory-destination add with carry writes accumulator plus byte, and carry, to memory; plain add omits carry.
// - Decimal adjust corrects the accumulator into memory, changing only carry.
// - AND, OR, XOR into the accumulator change only zero.
// - Memory-destination logic ops write memory, keep accumulator, change only zero.
// - Complement inverts all bits to memory or accumulator, changing only zero.
// - Increment and decrement change by one, changing only zero.
// - Plain rotates shift circularly by one and keep every flag.
// - Rotates through carry use carry as ninth bit, changing only carry.
// - Carry marks sums above 255; in subtraction a clear carry marks differences below 0.
// - Logic ops set zero exactly when their result is zero.
// - Bit set and clear change only the selected bit, internally read-modify-write.
// - Return resumes after the call; jump records no return point.
// - Conditional skips test a byte or bit and skip the next instruction.
// - Direct addressing reaches sector 0 only.
// - Writing the program counter low byte takes two instruction cycles.
// - A taken skip takes two cycles, an untaken one cycle.
module mad_core #(
	parameter int unsigned A_W = 8
) (
	input  wire logic           aclk,
	input  wire logic           aresetn,
	input  wire logic [A_W-1:0] s_axi_awaddr,
	input  wire logic           s_axi_awvalid,
	output logic                s_axi_awready,
	input  wire logic [31:0]    s_axi_wdata,
	input  wire logic [3:0]     s_axi_wstrb,
	input  wire logic           s_axi_wvalid,
	output logic                s_axi_wready,
	output logic [1:0]          s_axi_bresp,
	output logic                s_axi_bvalid,
	input  wire logic           s_axi_bready,
	input  wire logic [A_W-1:0] s_axi_araddr,
	input  wire logic           s_axi_arvalid,
	output logic                s_axi_arready,
	output logic [31:0]         s_axi_rdata,
	output logic [1:0]          s_axi_rresp,
	output logic                s_axi_rvalid,
	input  wire logic           s_axi_rready
);
	localparam int unsigned DIV_W = $clog2(mad_pkg::ICYC_CLKS);
	localparam int unsigned PW = mad_pkg::PC_W;

	typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_EXEC, ST_HOLD} mad_st_t;
	typedef struct packed {
		mad_st_t                                st;
		logic [DIV_W-1:0]                       div;
		logic [31:0]                            opcode;
		logic [7:0]                             acc;
		logic [mad_pkg::FLAG_W-1:0]             flags;
		logic [PW-1:0]                          pc;
		logic [mad_pkg::STACK_D-1:0][PW-1:0]    stack;
		logic [mad_pkg::MEM_AW-1:0]             maddr;
		logic [1:0]                             last_cyc;
		logic                                   skipped;
		logic                                   awready;
		logic                                   bvalid;
		logic [1:0]                             bresp;
		logic                                   arready;
		logic                                   rpend;
		logic [A_W-1:0]                         raddr;
		logic                                   rvalid;
		logic [1:0]                             rresp;
		logic [31:0]                            rdata;
	} mad_state_t;

	mad_state_t                 s;
	mad_state_t                 n;
	logic                       tick;
	logic                       commit;
	logic [4:0]                 fn;
	logic                       to_mem;
	logic [PW-1:0]              arg;
	logic [mad_pkg::MEM_AW-1:0] op_addr;
	logic                       pcl_hit;
	logic [7:0]                 mem_rdata;
	logic [7:0]                 opnd;
	logic [7:0]                 bmask;
	logic                       sub;
	logic [7:0]                 b_in;
	logic                       cin;
	logic [8:0]                 sum9;
	logic [4:0]                 nib5;
	logic                       ovf;
	logic [8:0]                 bcd_t;
	logic [8:0]                 bcd_u;
	logic [7:0]                 res;
	logic [mad_pkg::FLAG_W-1:0] fl;
	logic                       dst_mem;
	logic                       dst_acc;
	logic                       is_skip;
	logic                       skip;
	logic                       two;
	logic [PW-1:0]              pc_n;
	logic                       mem_we;
	logic                       mem_re;
	logic [mad_pkg::MEM_AW-1:0] mem_addr;
	logic [7:0]                 mem_wdata;
	logic                       aw_hs;
	logic [31:0]                wview;
	logic [31:0]                wm;
	logic [31:0]                rview;

	// Register view of one address, shared by reads and by strobe merges.
	function automatic logic [31:0] reg_view(input logic [A_W-1:0] ad);
		logic [31:0] v;
		v = 32'h0000_0000;
		if (ad == A_W'(mad_pkg::R_OPCODE)) v = s.opcode;
		if (ad == A_W'(mad_pkg::R_ACC)) v[7:0] = s.acc;
		if (ad == A_W'(mad_pkg::R_FLAGS)) v[mad_pkg::FLAG_W-1:0] = s.flags;
		if (ad == A_W'(mad_pkg::R_PC)) v[PW-1:0] = s.pc;
		if (ad == A_W'(mad_pkg::R_MADDR)) v[mad_pkg::MEM_AW-1:0] = s.maddr;
		if (ad == A_W'(mad_pkg::R_MDATA)) v[7:0] = mem_rdata;
		if (ad == A_W'(mad_pkg::R_STATE)) v[3:0] = {s.skipped, s.last_cyc, s.st != ST_IDLE};
		return v;
	endfunction

	// True for the offsets that exist; anything else answers with a slave error.
	function automatic logic mapped(input logic [A_W-1:0] ad);
		return ad == A_W'(mad_pkg::R_OPCODE) || ad == A_W'(mad_pkg::R_ACC) ||
			ad == A_W'(mad_pkg::R_FLAGS) || ad == A_W'(mad_pkg::R_PC) ||
			ad == A_W'(mad_pkg::R_MADDR) || ad == A_W'(mad_pkg::R_MDATA) ||
			ad == A_W'(mad_pkg::R_STATE);
	endfunction

	mad_ram #(
		.AW(mad_pkg::MEM_AW),
		.DW(8)
	) u_ram (
		.aclk    (aclk),
		.we      (mem_we),
		.re      (mem_re),
		.addr    (mem_addr),
		.wdata   (mem_wdata),
		.rdata_q (mem_rdata)
	);

	// Opcode decode; the operand address is cut to sector 0 width.
	assign fn = s.opcode[4:0];
	assign to_mem = s.opcode[mad_pkg::OP_TOMEM];
	assign arg = s.opcode[mad_pkg::OP_ARG_LSB +: PW];
	assign op_addr = arg[mad_pkg::MEM_AW-1:0];
	assign pcl_hit = op_addr == mad_pkg::PCLOW_ADDR;
	assign opnd = s.opcode[mad_pkg::OP_IMM] ? arg[7:0] : (pcl_hit ? s.pc[7:0] : mem_rdata);
	assign bmask = 8'h01 << s.opcode[mad_pkg::OP_BIT_LSB +: 3];
	assign tick = s.div == DIV_W'(mad_pkg::ICYC_CLKS - 1);
	assign commit = s.st == ST_EXEC && tick;
	assign aw_hs = s.awready && s_axi_awvalid && s_axi_wvalid;

	// One adder serves add and subtract; subtract adds the inverted operand.
	assign sub = fn == mad_pkg::FN_SUB || fn == mad_pkg::FN_SUB_B;
	assign b_in = sub ? ~opnd : opnd;
	assign cin = (fn == mad_pkg::FN_ADD_C || fn == mad_pkg::FN_SUB_B) ? s.flags[mad_pkg::F_CARRY] : sub;
	assign sum9 = {1'b0, s.acc} + {1'b0, b_in} + {8'h00, cin};
	assign nib5 = {1'b0, s.acc[3:0]} + {1'b0, b_in[3:0]} + {4'h0, cin};
	assign ovf = (s.acc[7] == b_in[7]) && (sum9[7] != s.acc[7]);
	// Decimal adjust: low digit first, then the high digit sees the low fix-up.
	assign bcd_t = (s.acc[3:0] > mad_pkg::BCD_DIGIT_MAX || s.flags[mad_pkg::F_NIB]) ?
		{1'b0, s.acc} + mad_pkg::BCD_LO_FIX : {1'b0, s.acc};
	assign bcd_u = (bcd_t[7:4] > mad_pkg::BCD_DIGIT_MAX || bcd_t[8] ||
		s.flags[mad_pkg::F_CARRY]) ? bcd_t + mad_pkg::BCD_HI_FIX : bcd_t;

	// Result, flags and destination of the instruction held in the opcode register.
	always_comb begin
		res = opnd;
		fl = s.flags;
		dst_mem = to_mem;
		dst_acc = !to_mem;
		is_skip = 1'b0;
		skip = 1'b0;
		two = 1'b0;
		pc_n = s.pc + PW'(1);
		case (fn)
			mad_pkg::FN_ADD, mad_pkg::FN_ADD_C, mad_pkg::FN_SUB, mad_pkg::FN_SUB_B: begin
				res = sum9[7:0];
				fl[mad_pkg::F_ZERO] = sum9[7:0] == 8'h00;
				fl[mad_pkg::F_CARRY] = sum9[8];
				fl[mad_pkg::F_NIB] = nib5[4];
				fl[mad_pkg::F_SRANGE] = ovf;
				fl[mad_pkg::F_SCMP] = sum9[7] ^ ovf;
				if (sub) begin
					fl[mad_pkg::F_CHZ] = (sum9[7:0] == 8'h00) &&
						(fn == mad_pkg::FN_SUB || s.flags[mad_pkg::F_CHZ]);
				end
			end
			mad_pkg::FN_AND, mad_pkg::FN_OR, mad_pkg::FN_XOR, mad_pkg::FN_INVERT,
			mad_pkg::FN_PLUS1, mad_pkg::FN_MINUS1: begin
				case (fn)
					mad_pkg::FN_AND: res = s.acc & opnd;
					mad_pkg::FN_OR: res = s.acc | opnd;
					mad_pkg::FN_XOR: res = s.acc ^ opnd;
					mad_pkg::FN_INVERT: res = ~opnd;
					mad_pkg::FN_PLUS1: res = opnd + 8'h01;
					default: res = opnd - 8'h01;
				endcase
				fl[mad_pkg::F_ZERO] = res == 8'h00;
			end
			mad_pkg::FN_ROT_R: res = {opnd[0], opnd[7:1]};
			mad_pkg::FN_ROT_L: res = {opnd[6:0], opnd[7]};
			mad_pkg::FN_ROT_RC: begin
				res = {s.flags[mad_pkg::F_CARRY], opnd[7:1]};
				fl[mad_pkg::F_CARRY] = opnd[0];
			end
			mad_pkg::FN_ROT_LC: begin
				res = {opnd[6:0], s.flags[mad_pkg::F_CARRY]};
				fl[mad_pkg::F_CARRY] = opnd[7];
			end
			mad_pkg::FN_BCD_ADJ: begin
				res = bcd_u[7:0];
				fl[mad_pkg::F_CARRY] = s.flags[mad_pkg::F_CARRY] | bcd_u[8];
				dst_mem = 1'b1;
				dst_acc = 1'b0;
			end
			mad_pkg::FN_BIT_SET, mad_pkg::FN_BIT_CLR: begin
				res = (fn == mad_pkg::FN_BIT_SET) ? opnd | bmask : opnd & ~bmask;
				dst_mem = 1'b1;
				dst_acc = 1'b0;
			end
			mad_pkg::FN_JUMP, mad_pkg::FN_CALL, mad_pkg::FN_EXIT: begin
				pc_n = (fn == mad_pkg::FN_EXIT) ? s.stack[0] : arg;
				two = 1'b1;
				dst_mem = 1'b0;
				dst_acc = 1'b0;
			end
			mad_pkg::FN_SKIP_Z, mad_pkg::FN_SKIP_NZ, mad_pkg::FN_SKIP_BZ, mad_pkg::FN_SKIP_BNZ: begin
				is_skip = 1'b1;
				skip = fn[1] ? ((opnd & bmask) == 8'h00) : (opnd == 8'h00);
				skip = skip ^ fn[0];
				two = skip;
				pc_n = s.pc + (skip ? PW'(2) : PW'(1));
				dst_mem = 1'b0;
				dst_acc = 1'b0;
			end
			default: begin
				dst_mem = 1'b0;
				dst_acc = 1'b0;
			end
		endcase
		// A store to the aliased location reloads the low program counter byte.
		if (dst_mem && pcl_hit) begin
			pc_n = {s.pc[PW-1:8], res};
			two = 1'b1;
		end
	end

	// Bus writes merge by byte strobe with the current view of the register.
	assign wview = reg_view(s_axi_awaddr);
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			wm[8*i +: 8] = s_axi_wstrb[i] ? s_axi_wdata[8*i +: 8] : wview[8*i +: 8];
		end
	end
	assign rview = reg_view(s.raddr);

	// Memory port: the datapath owns it while executing, the bus only when idle.
	always_comb begin
		mem_re = s.st == ST_FETCH;
		mem_we = commit && dst_mem && !pcl_hit;
		mem_addr = (s.st == ST_IDLE) ? s.maddr : op_addr;
		mem_wdata = (s.st == ST_IDLE) ? s_axi_wdata[7:0] : res;
		if (s.arready && s_axi_arvalid && s_axi_araddr == A_W'(mad_pkg::R_MDATA)) begin
			mem_re = 1'b1;
		end
		if (aw_hs && s_axi_awaddr == A_W'(mad_pkg::R_MDATA) && s_axi_wstrb[0]) begin
			mem_we = 1'b1;
		end
	end

	// Next state: divider, sequencer, commit and the AXI4-Lite slave.
	always_comb begin
		n = s;
		n.div = tick ? '0 : s.div + DIV_W'(1);
		case (s.st)
			ST_FETCH: n.st = ST_EXEC;
			ST_EXEC: begin
				if (commit) begin
					n.acc = dst_acc ? res : s.acc;
					n.flags = fl;
					n.pc = pc_n;
					n.skipped = skip;
					n.last_cyc = two ? 2'd2 : 2'd1;
					n.st = two ? ST_HOLD : ST_IDLE;
					if (fn == mad_pkg::FN_CALL) begin
						n.stack = {s.stack[mad_pkg::STACK_D-2:0], s.pc + PW'(1)};
					end
					if (fn == mad_pkg::FN_EXIT) begin
						n.stack = {PW'(0), s.stack[mad_pkg::STACK_D-1:1]};
					end
				end
			end
			ST_HOLD: n.st = tick ? ST_IDLE : ST_HOLD;
			default: n.st = ST_IDLE;
		endcase
		// Writes wait while an instruction runs, so no register changes under it.
		if (s.st == ST_IDLE && s_axi_awvalid && s_axi_wvalid && !s.awready && !s.bvalid &&
			!s.arready && !s.rpend) begin
			n.awready = 1'b1;
		end
		if (aw_hs) begin
			n.awready = 1'b0;
			n.bvalid = 1'b1;
			n.bresp = mapped(s_axi_awaddr) ? mad_pkg::RESP_OKAY : mad_pkg::RESP_SLVERR;
			if (s_axi_awaddr == A_W'(mad_pkg::R_OPCODE)) begin
				n.opcode = wm;
				n.st = ST_FETCH;
			end
			if (s_axi_awaddr == A_W'(mad_pkg::R_ACC)) n.acc = wm[7:0];
			if (s_axi_awaddr == A_W'(mad_pkg::R_FLAGS)) n.flags = wm[mad_pkg::FLAG_W-1:0];
			if (s_axi_awaddr == A_W'(mad_pkg::R_PC)) n.pc = wm[PW-1:0];
			if (s_axi_awaddr == A_W'(mad_pkg::R_MADDR)) n.maddr = wm[mad_pkg::MEM_AW-1:0];
		end
		if (s.bvalid && s_axi_bready) begin
			n.bvalid = 1'b0;
		end
		// A memory read is only taken when the port cannot be claimed by the datapath.
		if (s_axi_arvalid && !s.arready && !s.rpend && !s.rvalid &&
			(s_axi_araddr != A_W'(mad_pkg::R_MDATA) || (s.st == ST_IDLE && !s.awready))) begin
			n.arready = 1'b1;
		end
		if (s.arready && s_axi_arvalid) begin
			n.arready = 1'b0;
			n.rpend = 1'b1;
			n.raddr = s_axi_araddr;
		end
		if (s.rpend) begin
			n.rpend = 1'b0;
			n.rvalid = 1'b1;
			n.rdata = rview;
			n.rresp = mapped(s.raddr) ? mad_pkg::RESP_OKAY : mad_pkg::RESP_SLVERR;
		end
		if (s.rvalid && s_axi_rready) begin
			n.rvalid = 1'b0;
		end
	end

	// Single register stage for all state.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign s_axi_awready = s.awready;
	assign s_axi_wready = s.awready;
	assign s_axi_bvalid = s.bvalid;
	assign s_axi_bresp = s.bresp;
	assign s_axi_arready = s.arready;
	assign s_axi_rvalid = s.rvalid;
	assign s_axi_rresp = s.rresp;
	assign s_axi_rdata = s.rdata;

	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// Helper: reference sum built apart from the shared adder.
	logic [8:0] ref_add;
	assign ref_add = {1'b0, s.acc} + {1'b0, opnd};

	sequence seq_hold_one_cycle;
		(s.st == ST_HOLD) [*3] ##1 (s.st == ST_HOLD && tick) ##1 (s.st == ST_IDLE);
	endsequence

	a_add_acc_sum: assert property (commit && fn == mad_pkg::FN_ADD && !to_mem |=>
		{s.flags[mad_pkg::F_CARRY], s.acc} == $past(ref_add)) else $error("add result wrong");
	a_sub_into_mem: assert property (commit && fn == mad_pkg::FN_SUB && to_mem && !pcl_hit
		|-> mem_we && mem_wdata == 8'(s.acc - opnd)) else $error("subtract store wrong");
	a_addc_into_mem: assert property (commit && fn == mad_pkg::FN_ADD_C && to_mem && !pcl_hit
		|-> mem_wdata == 8'(ref_add + {8'h00, s.flags[mad_pkg::F_CARRY]})) else $error("add store wrong");
	a_bcd_only_carry: assert property (commit && fn == mad_pkg::FN_BCD_ADJ |=>
		$stable(s.acc) && $stable(s.flags[mad_pkg::F_ZERO])) else $error("decimal adjust side effect");
	a_logic_zero: assert property (commit && fn == mad_pkg::FN_XOR && !to_mem |=>
		s.flags[mad_pkg::F_ZERO] == (s.acc == 8'h00)) else $error("logic zero flag wrong");
	a_rotate_keeps: assert property (commit && (fn == mad_pkg::FN_ROT_R || fn == mad_pkg::FN_ROT_L)
		|=> $stable(s.flags)) else $error("plain rotate changed a flag");
	a_bit_single: assert property (commit && fn == mad_pkg::FN_BIT_CLR && !pcl_hit
		|-> mem_we && ((mem_wdata ^ opnd) & ~bmask) == 8'h00) else $error("other bits changed");
	a_skip_two: assert property (commit && skip |=> seq_hold_one_cycle)
		else $error("taken skip not two cycles");
	a_call_return: assert property (commit && fn == mad_pkg::FN_CALL |=>
		s.stack[0] == $past(s.pc) + PW'(1)) else $error("return point wrong");
	a_acc_no_store: assert property (s.st == ST_EXEC && !to_mem && fn != mad_pkg::FN_BCD_ADJ &&
		fn != mad_pkg::FN_BIT_SET && fn != mad_pkg::FN_BIT_CLR |-> !mem_we) else $error("stray store");
endmodule // mad_core

// File: testbench/mad_seq_model.sv
// Sequencer model that issues AXI4-Lite register transfers to the datapath.
`timescale 1ns/1ps
module mad_seq_model (
	input  wire logic        aclk,
	output logic [7:0]       awaddr,
	output logic             awvalid,
	input  wire logic        awready,
	output logic [31:0]      wdata,
	output logic [3:0]       wstrb,
	output logic             wvalid,
	input  wire logic        wready,
	input  wire logic [1:0]  bresp,
	input  wire logic        bvalid,
	output logic             bready,
	output logic [7:0]       araddr,
	output logic             arvalid,
	input  wire logic        arready,
	input  wire logic [31:0] rdata,
	input  wire logic [1:0]  rresp,
	input  wire logic        rvalid,
	output logic             rready
);
	// All requests idle from time zero, so nothing precedes reset release.
	initial {awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready} = '0;

	// Write: address and data offered together, each released when taken.
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		bready <= 1'b0;
		r = bresp;
	endtask

	// Read: rready stays high until the answer is sampled.
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready === 1'b1) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rready <= 1'b0;
		d = rdata;
		r = rresp;
	endtask
endmodule // mad_seq_model

// File: testbench/tb.sv
// Self-checking bench for the sector-0 instruction datapath.
`timescale 1ns/1ps
module tb;
	logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, v;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, rs;
	int          errors, n_tests;

	// Design under test and the sequencer model on its register bus.
	mad_core u_mad_core (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready));
	mad_seq_model u_mad_seq_model (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready));

	// A 50 ns clock.
	initial begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			errors++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
		u_mad_seq_model.rd(a, v, rs);
		chk(nm, e, v);
	endtask
	task automatic put(input logic [7:0] a, input logic [31:0] d);
		u_mad_seq_model.wr(a, d, rs);
		chk("write resp", {30'h0, mad_pkg::RESP_OKAY}, {30'h0, rs});
	endtask
	function automatic logic [31:0] op(input logic [4:0] fn, input logic tm, input logic im,
		input logic [2:0] b, input logic [11:0] arg);
		return {4'h0, arg, 5'h00, b, 1'b0, im, tm, fn};
	endfunction
	// Starts an instruction and polls busy; the poll is bounded so a stuck core fails fast.
	task automatic run(input logic [31:0] o);
		int i;
		put(mad_pkg::R_OPCODE, o);
		v = 32'h1;
		for (i = 0; i < 20 && v[0] !== 1'b0; i++) u_mad_seq_model.rd(mad_pkg::R_STATE, v, rs);
		// A core still busy after the poll limit counts as a mismatch here.
		chk("run idle", 32'h0, {31'h0, v[0]});
	endtask
	task automatic complete_run();
		$display("counts errors %0d comparisons %0d", errors, n_tests);
		if (errors == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// Main sequence; each test from sub through branch leaves state that the next one relies on.
	initial begin
		errors = 0;
		n_tests = 0;
		aresetn = 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		rdc("reset acc", mad_pkg::R_ACC, 32'h0);
		rdc("reset flags", mad_pkg::R_FLAGS, 32'h0);
		put(mad_pkg::R_ACC, 32'hf0);
		run(op(mad_pkg::FN_ADD, 1'b0, 1'b1, 3'h0, 12'h020));
		rdc("add acc", mad_pkg::R_ACC, 32'h10);
		rdc("add flags", mad_pkg::R_FLAGS, 32'h02);
		rdc("add cycles", mad_pkg::R_STATE, 32'h2);
		$display("test add done");
		put(mad_pkg::R_MADDR, 32'h10);
		put(mad_pkg::R_MDATA, 32'h07);
		put(mad_pkg::R_ACC, 32'h05);
		run(op(mad_pkg::FN_SUB, 1'b1, 1'b0, 3'h0, 12'h010));
		rdc("sub mem", mad_pkg::R_MDATA, 32'hfe);
		rdc("sub acc", mad_pkg::R_ACC, 32'h05);
		rdc("sub flags", mad_pkg::R_FLAGS, 32'h10);
		$display("test sub done");
		run(op(mad_pkg::FN_ROT_LC, 1'b0, 1'b0, 3'h0, 12'h010));
		rdc("rlc acc", mad_pkg::R_ACC, 32'hfc);
		rdc("rlc flags", mad_pkg::R_FLAGS, 32'h12);
		rdc("rlc mem", mad_pkg::R_MDATA, 32'hfe);
		run(op(mad_pkg::FN_AND, 1'b0, 1'b1, 3'h0, 12'h003));
		rdc("and acc", mad_pkg::R_ACC, 32'h0);
		rdc("and flags", mad_pkg::R_FLAGS, 32'h13);
		run(op(mad_pkg::FN_BIT_SET, 1'b1, 1'b0, 3'h0, 12'h010));
		rdc("bit set mem", mad_pkg::R_MDATA, 32'hff);
		rdc("bit set flags", mad_pkg::R_FLAGS, 32'h13);
		$display("test logic done");
		run(op(mad_pkg::FN_JUMP, 1'b0, 1'b0, 3'h0, 12'h123));
		rdc("jump pc", mad_pkg::R_PC, 32'h123);
		rdc("jump cycles", mad_pkg::R_STATE, 32'h4);
		run(op(mad_pkg::FN_CALL, 1'b0, 1'b0, 3'h0, 12'h050));
		rdc("call pc", mad_pkg::R_PC, 32'h050);
		run(op(mad_pkg::FN_EXIT, 1'b0, 1'b0, 3'h0, 12'h000));
		rdc("return pc", mad_pkg::R_PC, 32'h124);
		run(op(mad_pkg::FN_SKIP_Z, 1'b0, 1'b0, 3'h0, 12'h010));
		rdc("skip none", mad_pkg::R_STATE, 32'h2);
		run(op(mad_pkg::FN_SKIP_NZ, 1'b0, 1'b0, 3'h0, 12'h010));
		rdc("skip taken", mad_pkg::R_STATE, 32'hc);
		$display("test branch done");
		run(op(mad_pkg::FN_XOR, 1'b0, 1'b1, 3'h0, 12'h05a));
		rdc("xor acc", mad_pkg::R_ACC, 32'h5a);
		rdc("xor flags", mad_pkg::R_FLAGS, 32'h12);
		run(op(mad_pkg::FN_INVERT, 1'b1, 1'b0, 3'h0, 12'h010));
		rdc("invert mem", mad_pkg::R_MDATA, 32'h00);
		rdc("invert flags", mad_pkg::R_FLAGS, 32'h13);
		run(op(mad_pkg::FN_PLUS1, 1'b0, 1'b0, 3'h0, 12'h010));
		rdc("plus one acc", mad_pkg::R_ACC, 32'h01);
		rdc("plus one flags", mad_pkg::R_FLAGS, 32'h12);
		run(op(mad_pkg::FN_ROT_R, 1'b0, 1'b1, 3'h0, 12'h001));
		rdc("rotate acc", mad_pkg::R_ACC, 32'h80);
		rdc("rotate flags", mad_pkg::R_FLAGS, 32'h12);
		run(op(mad_pkg::FN_ADD_C, 1'b1, 1'b0, 3'h0, 12'h010));
		rdc("addc mem", mad_pkg::R_MDATA, 32'h81);
		rdc("addc flags", mad_pkg::R_FLAGS, 32'h10);
		run(op(mad_pkg::FN_SUB_B, 1'b0, 1'b1, 3'h0, 12'h001));
		rdc("sbc acc", mad_pkg::R_ACC, 32'h7e);
		rdc("sbc flags", mad_pkg::R_FLAGS, 32'h1a);
		run(op(mad_pkg::FN_BCD_ADJ, 1'b1, 1'b0, 3'h0, 12'h010));
		rdc("bcd mem", mad_pkg::R_MDATA, 32'he4);
		rdc("bcd flags", mad_pkg::R_FLAGS, 32'h1a);
		run(op(mad_pkg::FN_SKIP_BZ, 1'b0, 1'b0, 3'h0, 12'h010));
		rdc("bit skip", mad_pkg::R_STATE, 32'hc);
		put(mad_pkg::R_PC, 32'h120);
		run(op(mad_pkg::FN_BIT_SET, 1'b1, 1'b0, 3'h0, 12'h006));
		rdc("pcl pc", mad_pkg::R_PC, 32'h121);
		rdc("pcl cycles", mad_pkg::R_STATE, 32'h4);
		$display("test extra ops done");
		u_mad_seq_model.rd(8'h1c, v, rs);
		chk("unmapped resp", {30'h0, mad_pkg::RESP_SLVERR}, {30'h0, rs});
		$display("test unmapped done");
		complete_run();
	end

	// Watchdog well beyond the fewer than one thousand cycles the tests need.
	initial begin
		repeat (20000) @(posedge aclk);
		errors++;
		complete_run();
	end
endmodule // tb
